/* verilog/ssss_top.sv */
/*
 * SPI port with slave-select synchronisation and sleep behaviour,
 * registers on APB. Assumes sclk_in, sdi, ss_n synchronous to pclk and
 * slower than pclk/4; sleep_req models the core's sleep state.
 */
// Behaviour
// - select mode only when mode field is 0100
// - select low enables transfer and drives output
// - select high releases data output at once
// - select high resets the serial module
// - module reset clears bit counter to zero
// - master freezes during sleep, resumes after
// - slave shifts in sleep, byte wakes core
// - MSB first, byte moves to buffer, flags
// - busy write ignored, sets collision flag
`timescale 1ns/10ps
`include "ssss_map.svh"

module ssss_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    input  wire logic        ss_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    output logic             wake
);
    // Control and status bits kept as flops; status keeps only its two
    // writable bits and the full flag, the rest read as zero
    // Register state
    logic [7:0]  serial_data_buffer;    // Received byte
    logic [7:0]  serial_control_one;    // Collision, overflow, enable, polarity, mode
    logic [7:0]  serial_control_three;  // Stored only
    logic [1:0]  stat_cfg;              // Sample phase and clock edge bits
    logic        buffer_full_flag;
    logic        port_interrupt_flag;
    logic        port_interrupt_enable;
    logic        sleep_req;
    // One byte engine shared by the master and both slave roles
    // Shift engine
    logic [7:0]  transfer_shift_register;
    logic [2:0]  bit_cnt;
    logic        busy;
    logic        sclk_q;                // Previous serial clock level
    logic [3:0]  div_cnt;               // Master half-period counter
    // Computed in one process below and registered in one process
    // Next values
    logic [7:0]  next_buf, next_con1, next_con3, next_sr;
    logic [1:0]  next_stat;
    logic        next_bf, next_if, next_ie, next_sleep, next_busy, next_sclk_q;
    logic [2:0]  next_cnt;
    logic [3:0]  next_div;
    logic [31:0] next_prdata;
    logic        next_sdo, next_sdo_oe, next_sclk_out, next_sclk_oe, next_wake, next_err;

    // The role decides which clock drives the engine
    // Decoded configuration
    ssss_pkg::ssss_role_t role;
    logic port_enable_bit;
    logic [3:0] port_mode_field;
    logic ckp, cke, lead_edge, trail_edge, sample_edge, shift_edge, mod_reset;
    logic cur_clk, wr_acc, rd_acc;
    logic addr_ok;                      // Offset hits one of the five registers

    always_comb begin
        port_enable_bit = serial_control_one[`SSSS_CON1_EN];
        port_mode_field = serial_control_one[3:0];
        ckp             = serial_control_one[`SSSS_CON1_CKP];
        cke             = stat_cfg[0];
        if (!port_enable_bit)
            role = ssss_pkg::SSSS_ROLE_OFF;
        else if (port_mode_field == `SSSS_MODE_SLV_SS)
            role = ssss_pkg::SSSS_ROLE_SLAVE_SS;
        else if (port_mode_field == `SSSS_MODE_SLV)
            role = ssss_pkg::SSSS_ROLE_SLAVE;
        else
            role = ssss_pkg::SSSS_ROLE_MASTER;
    end

    // Serial inputs are taken as synchronous; an edge is a level change
    // seen between two pclk samples, so the link must run slower
    // Clock source and edge detection; idle level set by polarity bit
    always_comb begin
        cur_clk = (role == ssss_pkg::SSSS_ROLE_MASTER) ? sclk_out : sclk_in;
        // Edge away from idle, then edge back to idle
        lead_edge  = (cur_clk != sclk_q) && (cur_clk != ckp);
        trail_edge = (cur_clk != sclk_q) && (cur_clk == ckp);
        // Clock-edge bit has no effect: output changes on the edge away from idle
        sample_edge = cke ? lead_edge : lead_edge;
        shift_edge  = trail_edge;
        // select high resets the module in select mode
        // disabling the port resets it as well
        mod_reset = !port_enable_bit || ((role == ssss_pkg::SSSS_ROLE_SLAVE_SS) && ss_n);
        // Writes land at the edge where pready is seen high, so a write
        // acts once although the access phase spans two cycles
        wr_acc = psel && penable && pready && pwrite;
        // Read data is captured in the first access cycle so that it
        // stands on prdata in the cycle in which pready is high
        rd_acc = psel && penable && !pready && !pwrite;
        addr_ok = (paddr == `SSSS_OFF_BUF) || (paddr == `SSSS_OFF_CON1) ||
                  (paddr == `SSSS_OFF_CON3) || (paddr == `SSSS_OFF_STAT) ||
                  (paddr == `SSSS_OFF_SYS);
    end

    // Register, shift and pin next-state logic
    always_comb begin
        next_buf    = serial_data_buffer;
        next_con1   = serial_control_one;
        next_con3   = serial_control_three;
        next_stat   = stat_cfg;
        next_bf     = buffer_full_flag;
        next_if     = port_interrupt_flag;
        next_ie     = port_interrupt_enable;
        next_sleep  = sleep_req;
        next_sr     = transfer_shift_register;
        next_cnt    = bit_cnt;
        next_busy   = busy;
        next_sclk_q = cur_clk;
        next_div    = div_cnt;
        next_sclk_out = sclk_out;
        next_prdata = 32'h0000_0000;
        // Error answer rides with pready for unmapped offsets
        next_err    = psel && penable && !pready && !addr_ok;

        // Hardware events are applied after the bus, so a flag that is
        // set and cleared in one cycle is left set
        // Bus writes first; hardware events below win over clears
        if (wr_acc) begin
            unique case (paddr)
                `SSSS_OFF_BUF: begin
                    // Collision stays set until control one is written again
                    // write during transfer is refused
                    if (busy || serial_control_one[`SSSS_CON1_COLL]) begin
                        next_con1[`SSSS_CON1_COLL] = 1'b1;
                    end else begin
                        next_sr   = pwdata[7:0];
                        next_busy = port_enable_bit;
                    end
                end
                `SSSS_OFF_CON1: next_con1 = pwdata[7:0];
                `SSSS_OFF_CON3: next_con3 = pwdata[7:0];
                `SSSS_OFF_STAT: next_stat = pwdata[7:6];
                `SSSS_OFF_SYS: begin
                    next_sleep = pwdata[`SSSS_SYS_SLEEP];
                    next_ie    = pwdata[`SSSS_SYS_IE];
                    // Writing zero clears the interrupt flag
                    if (!pwdata[`SSSS_SYS_IF])
                        next_if = 1'b0;
                end
                // Unmapped offsets change nothing
                default: ;
            endcase
        end
        // Reading the buffer clears the full flag in the first access cycle
        if (rd_acc) begin
            unique case (paddr)
                `SSSS_OFF_BUF: begin
                    next_prdata = {24'h00_0000, serial_data_buffer};
                    next_bf     = 1'b0;
                end
                `SSSS_OFF_CON1: next_prdata = {24'h00_0000, serial_control_one};
                `SSSS_OFF_CON3: next_prdata = {24'h00_0000, serial_control_three};
                `SSSS_OFF_STAT: next_prdata = {24'h00_0000, stat_cfg, 5'h00, buffer_full_flag};
                `SSSS_OFF_SYS:  next_prdata = {29'h0000_0000, port_interrupt_flag,
                                               port_interrupt_enable, sleep_req};
                default: next_prdata = 32'h0000_0000;
            endcase
        end

        // Half period is five pclk cycles: the counter runs 0 to 4
        // Outside a transfer the clock rests at its idle level
        // Limitation: one fixed rate, no programmable divider
        // Master clock generator
        // in sleep the master clock and counter stand still
        if (role == ssss_pkg::SSSS_ROLE_MASTER && busy && !sleep_req) begin
            if (div_cnt == `SSSS_MST_HALF) begin
                next_div      = 4'h0;
                next_sclk_out = !sclk_out;
            end else begin
                next_div = div_cnt + 4'h1;
            end
        end else if (role != ssss_pkg::SSSS_ROLE_MASTER || !busy) begin
            next_div      = 4'h0;
            next_sclk_out = ckp;
        end

        // Module reset keeps the shift register contents, so a byte
        // loaded for sending survives a high select and goes out
        // when the master next frames a transfer
        if (mod_reset) begin
            next_cnt  = `SSSS_BIT_ZERO;
            next_busy = 1'b0;
            if (!port_enable_bit)
                next_sclk_out = ckp;
        end else if (role != ssss_pkg::SSSS_ROLE_MASTER || !sleep_req) begin
            if (role != ssss_pkg::SSSS_ROLE_MASTER && sample_edge)
                next_busy = 1'b1;
            if (sample_edge) begin
                // MSB first into the shift register
                next_sr = {transfer_shift_register[6:0], sdi};
                if (bit_cnt == `SSSS_BIT_LAST) begin
                    next_cnt  = `SSSS_BIT_ZERO;
                    next_busy = 1'b0;
                    // completed byte to buffer, flags set
                    next_buf  = {transfer_shift_register[6:0], sdi};
                    if (buffer_full_flag)
                        next_con1[`SSSS_CON1_OV] = 1'b1;
                    next_bf   = 1'b1;
                    next_if   = 1'b1;
                end else begin
                    next_cnt = bit_cnt + 3'h1;
                end
            end
        end

        // Trade-off: the output bit follows the shift register at once,
        // which costs no extra flop but ties output timing to sampling
        // select low drives the data output
        // select high releases it at once
        next_sdo     = next_sr[7];
        next_sclk_oe = (role == ssss_pkg::SSSS_ROLE_MASTER);
        unique case (role)
            ssss_pkg::SSSS_ROLE_SLAVE_SS: next_sdo_oe = !ss_n;
            ssss_pkg::SSSS_ROLE_OFF:      next_sdo_oe = 1'b0;
            default:                      next_sdo_oe = 1'b1;
        endcase
        // Wake lasts one cycle: it clears the sleep request it answers
        // enabled byte interrupt wakes a sleeping core
        next_wake = next_if && next_ie && sleep_req;
        if (next_wake)
            next_sleep = 1'b0;
        if (shift_edge) begin
            next_sdo = next_sr[7];
        end
    end

    // All outputs leave from these flip-flops, never from logic,
    // so the pins carry no glitch from the decode above
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_data_buffer      <= `SSSS_RST_BYTE;
            serial_control_one      <= `SSSS_RST_BYTE;
            serial_control_three    <= `SSSS_RST_BYTE;
            stat_cfg                <= 2'b00;
            buffer_full_flag        <= 1'b0;
            port_interrupt_flag     <= 1'b0;
            port_interrupt_enable   <= 1'b0;
            sleep_req               <= 1'b0;
            transfer_shift_register <= `SSSS_RST_BYTE;
            bit_cnt                 <= `SSSS_BIT_ZERO;
            busy                    <= 1'b0;
            sclk_q                  <= 1'b0;
            div_cnt                 <= 4'h0;
            sclk_out                <= 1'b0;
            sclk_oe                 <= 1'b0;
            sdo                     <= 1'b0;
            sdo_oe                  <= 1'b0;
            wake                    <= 1'b0;
            prdata                  <= 32'h0000_0000;
            pslverr                 <= 1'b0;
            pready                  <= 1'b0;
        end else begin
            serial_data_buffer      <= next_buf;
            serial_control_one      <= next_con1;
            serial_control_three    <= next_con3;
            stat_cfg                <= next_stat;
            buffer_full_flag        <= next_bf;
            port_interrupt_flag     <= next_if;
            port_interrupt_enable   <= next_ie;
            sleep_req               <= next_sleep;
            transfer_shift_register <= next_sr;
            bit_cnt                 <= next_cnt;
            busy                    <= next_busy;
            sclk_q                  <= next_sclk_q;
            div_cnt                 <= next_div;
            sclk_out                <= next_sclk_out;
            sclk_oe                 <= next_sclk_oe;
            sdo                     <= next_sdo;
            sdo_oe                  <= next_sdo_oe;
            wake                    <= next_wake;
            prdata                  <= next_prdata;
            pslverr                 <= next_err;
            // A second access cycle never sees pready low, so the slave
            // answers exactly once per transfer
            // Access phase answered once: pready high in the cycle after penable
            pready                  <= psel && penable && !pready;
        end
    end
endmodule : ssss_top

/* verilog/ssss_map.svh */
/*
 * Register offsets, field positions, reset values and modes of the
 * serial port with slave-select synchronisation and sleep handling.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SSSS_MAP_SVH
`define SSSS_MAP_SVH

// APB byte offsets
`define SSSS_OFF_BUF      12'h000
`define SSSS_OFF_CON1     12'h004
`define SSSS_OFF_CON3     12'h008
`define SSSS_OFF_STAT     12'h00C
`define SSSS_OFF_SYS      12'h010

// Control register one fields
`define SSSS_CON1_COLL    7
`define SSSS_CON1_OV      6
`define SSSS_CON1_EN      5
`define SSSS_CON1_CKP     4

// Status register fields
`define SSSS_STAT_PHASE   7
`define SSSS_STAT_CKE     6
`define SSSS_STAT_FULL    0

// System register fields (sleep request, interrupt enable/flag)
`define SSSS_SYS_SLEEP    0
`define SSSS_SYS_IE       1
`define SSSS_SYS_IF       2

// Mode field patterns
`define SSSS_MODE_SLV_SS  4'h4
`define SSSS_MODE_SLV     4'h5

// Reset values and last bit count
`define SSSS_RST_BYTE     8'h00
`define SSSS_BIT_ZERO     3'h0
`define SSSS_BIT_LAST     3'h7

// Master clock divider: last count of a half period of five pclk cycles
`define SSSS_MST_HALF     4'h4

`endif

/* verilog/ssss_pkg.sv */
/*
 * Types of the serial port block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ssss_pkg;
    // Port role chosen by the mode field
    typedef enum logic [1:0] {
        SSSS_ROLE_OFF,
        SSSS_ROLE_MASTER,
        SSSS_ROLE_SLAVE,
        SSSS_ROLE_SLAVE_SS
    } ssss_role_t;
endpackage : ssss_pkg

/* test/ssss_checker.sv */
/* Checker of APB answer timing, select gating of the data output and wake.
   Assumes a bind to ssss_top; it tracks control writes from the bus itself. */
`timescale 1ns/10ps
`include "ssss_map.svh"
module ssss_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ss_n,
    input wire logic        sclk_oe,
    input wire logic        sdo_oe,
    input wire logic        wake
);
    logic [7:0] con1, next_con1; // Control one as last written
    logic       ie, next_ie;     // Interrupt enable as last written
    logic       ssm;             // Select-controlled slave mode
    logic       slv;             // Either slave mode
    // Follow only completed writes; the collision bit is not tracked
    always_comb begin
        next_con1 = con1;
        next_ie = ie;
        if (psel && penable && pready && pwrite && paddr == `SSSS_OFF_CON1) next_con1 = pwdata[7:0];
        if (psel && penable && pready && pwrite && paddr == `SSSS_OFF_SYS) next_ie = pwdata[1];
    end
    // Register the mirror
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con1 <= 8'h00;
            ie <= 1'b0;
        end else begin
            con1 <= next_con1;
            ie <= next_ie;
        end
    end
    assign ssm = con1[`SSSS_CON1_EN] && con1[3:0] == `SSSS_MODE_SLV_SS;
    assign slv = con1[`SSSS_CON1_EN] && con1[3:1] == 3'h2;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    a_bad_addr: assert property (psel && penable && !pready && paddr > 12'h010 |=> pslverr)
        else $error("unmapped address not refused");
    a_sel_drive: assert property ($past(ssm) && !$past(ss_n) |-> sdo_oe)
        else $error("data output not driven while selected");
    a_sel_release: assert property ($past(ssm) && $past(ss_n) |-> !sdo_oe)
        else $error("data output driven while deselected");
    a_wake_ie: assert property (wake |-> $past(ie))
        else $error("wake without interrupt enable");
    a_slave_clk: assert property ($past(slv) |-> !sclk_oe)
        else $error("clock driven in slave mode");
    cover property ($fell(sdo_oe));
    cover property (wake);
    cover property (pslverr);
endmodule : ssss_checker

/* test/ssss_spi_mst.sv */
/* External SPI master: clock idles low, select frames a transfer when asked.
   Assumes the slave samples on the rising clock edge, MSB first. */
`timescale 1ns/10ps
module ssss_spi_mst (
    input  wire logic pclk,
    output logic      sclk_in,
    output logic      ss_n,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    logic miso; // Data line as this master sees it
    // A released line toggles, so a stale bit never reads as good data
    always @(posedge pclk) miso <= sdo_oe ? sdo : ~miso;
    initial {sclk_in, ss_n, sdi, miso} = 4'h4;
    // Shift nb bits with half period h; frame lowers the select around them
    task xfer(input logic [7:0] tx, input int nb, input int h, input bit frame,
              output logic [7:0] rx);
        rx = 8'h00;
        // select low only within a transfer
        if (frame) ss_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            sdi <= tx[7-i];
            repeat (h) @(posedge pclk);
            sclk_in <= 1'b1;
            rx = {rx[6:0], miso};
            repeat (h) @(posedge pclk);
            sclk_in <= 1'b0;
        end
        repeat (h) @(posedge pclk);
        ss_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : xfer
endmodule : ssss_spi_mst

/* test/tb_spi_slave_select_sleep.sv */
/* Self-checking bench of the select-synchronised serial port.
   Assumes ssss_top, the checker and the master model are compiled first. */
`timescale 1ns/10ps
`include "ssss_map.svh"
module tb_spi_slave_select_sleep;
    localparam logic [31:0] zero = 32'h0000_0000;
    localparam logic [31:0] one = 32'h0000_0001;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e, woke;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_d;
    logic        sclk_in, ss_n, sdi, sdo, sdo_oe, wake, sclk_out, sclk_oe;
    logic [7:0]  rx;
    int          n_mismatch, samples_checked, cyc;
    ssss_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sclk_in, .sclk_out, .sclk_oe, .ss_n, .sdi, .sdo, .sdo_oe, .wake);
    ssss_spi_mst mst (.pclk, .sclk_in, .ss_n, .sdi, .sdo, .sdo_oe);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard; wake is short-lived, so it is latched here
    always @(posedge pclk) begin
        if (wake === 1'b1) woke <= 1'b1;
        cyc = cyc + 1;
        if (cyc == 8000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, entered and left just after a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the hang guard ends a lost one
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_d = prdata;
        rd_e = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask : apb
    // framed byte both ways, flags, unmapped read
    task t_frame;
        apb(1'b1, `SSSS_OFF_CON1, 32'h0000_0024);
        apb(1'b1, `SSSS_OFF_STAT, 32'h0000_0040);
        apb(1'b1, `SSSS_OFF_BUF, 32'h0000_00A5);
        mst.xfer(8'h3C, 8, 4, 1'b1, rx);
        chk({24'h00_0000, rx}, 32'h0000_00A5);
        apb(1'b0, `SSSS_OFF_STAT, zero);
        chk(rd_d & one, one);
        chk(rd_d & 32'h0000_00C0, 32'h0000_0040);
        apb(1'b0, `SSSS_OFF_BUF, zero);
        chk(rd_d, 32'h0000_003C);
        apb(1'b0, 12'h020, zero);
        chk({31'h0, rd_e}, one);
    endtask : t_frame
    // clocks ignored when deselected, partial byte discarded
    task t_resync;
        mst.xfer(8'hFF, 8, 4, 1'b0, rx);
        apb(1'b0, `SSSS_OFF_STAT, zero);
        chk(rd_d & one, zero);
        mst.xfer(8'h00, 3, 4, 1'b1, rx);
        chk({31'h0, sdo_oe}, zero);
        mst.xfer(8'h81, 8, 8, 1'b1, rx);
        apb(1'b0, `SSSS_OFF_BUF, zero);
        chk(rd_d, 32'h0000_0081);
    endtask : t_resync
    // buffer write in mid-transfer is refused
    task t_collide;
        fork
            mst.xfer(8'h11, 8, 4, 1'b1, rx);
            begin
                repeat (12) @(posedge pclk);
                apb(1'b1, `SSSS_OFF_BUF, 32'h0000_0055);
            end
        join
        apb(1'b0, `SSSS_OFF_CON1, zero);
        chk(rd_d, 32'h0000_00A4);
        apb(1'b1, `SSSS_OFF_CON1, 32'h0000_0024);
        apb(1'b0, `SSSS_OFF_BUF, zero);
        chk(rd_d, 32'h0000_0011);
    endtask : t_collide
    // byte received in sleep wakes the core
    task t_sleep;
        chk({31'h0, woke}, zero);
        apb(1'b1, `SSSS_OFF_SYS, 32'h0000_0003);
        mst.xfer(8'h5A, 8, 4, 1'b1, rx);
        chk({31'h0, woke}, one);
        apb(1'b0, `SSSS_OFF_SYS, zero);
        chk(rd_d & 32'h0000_0007, 32'h0000_0006);
        apb(1'b1, `SSSS_OFF_SYS, zero);
        apb(1'b0, `SSSS_OFF_BUF, zero);
        chk(rd_d, 32'h0000_005A);
    endtask : t_sleep
    // mode 0101 receives without the select
    task t_nosel;
        apb(1'b1, `SSSS_OFF_STAT, zero);
        apb(1'b1, `SSSS_OFF_CON1, 32'h0000_0025);
        mst.xfer(8'hC3, 8, 4, 1'b0, rx);
        apb(1'b0, `SSSS_OFF_BUF, zero);
        chk(rd_d, 32'h0000_00C3);
    endtask : t_nosel
    // master transfer freezes in sleep and resumes when a bus write clears sleep
    task t_master;
        logic lvl, moved;
        moved = 1'b0;
        apb(1'b1, `SSSS_OFF_CON1, 32'h0000_0020);
        apb(1'b1, `SSSS_OFF_BUF, 32'h0000_0096);
        repeat (12) @(posedge pclk);
        apb(1'b1, `SSSS_OFF_SYS, one);
        lvl = sclk_out;
        repeat (37) begin
            @(posedge pclk);
            if (sclk_out !== lvl)
                moved = 1'b1;
        end
        chk({31'h0, moved}, zero);
        chk({31'h0, sclk_oe}, one);
        apb(1'b0, `SSSS_OFF_STAT, zero);
        chk(rd_d & one, zero);
        apb(1'b1, `SSSS_OFF_SYS, zero);
        repeat (100) @(posedge pclk);
        apb(1'b0, `SSSS_OFF_STAT, zero);
        chk(rd_d & one, one);
        // The model leaves its data line at the last bit sent, a one
        apb(1'b0, `SSSS_OFF_BUF, zero);
        chk(rd_d, 32'h0000_00FF);
    endtask : t_master
    initial begin
        {psel, penable, pwrite, presetn, woke, paddr, pwdata} = '0;
        {n_mismatch, samples_checked, cyc} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_frame();
        t_resync();
        t_collide();
        t_sleep();
        t_nosel();
        t_master();
        conclude();
    end
endmodule : tb_spi_slave_select_sleep
bind ssss_top ssss_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ss_n, .sclk_oe, .sdo_oe, .wake);
